// ---- verilog/dasc_pkg.sv ----
// Purpose: constants for the debug arm and state control core
// Assumes: 8-bit registers on a 32-bit APB data bus, one word each
// Notes: printed offsets are not multiples of four; they are indices
package dasc_pkg;
    localparam logic [7:0] DASC_IDX_CTL1 = 8'h20;
    localparam logic [7:0] DASC_IDX_STAT = 8'h21;
    localparam logic [7:0] DASC_IDX_TCTL = 8'h22;
    localparam logic [7:0] DASC_IDX_CNT = 8'h26;
    localparam logic [7:0] DASC_IDX_SHARED = 8'h27;
    localparam logic [7:0] DASC_IDX_BREAK = 8'h30;
    localparam int DASC_ARM_BIT = 7;
    localparam int DASC_IMMEDIATE_TRIGGER_REQ_BIT = 6;
    localparam int DASC_BGSEL_BIT = 4;
    localparam int DASC_FBRK_BIT = 3;
    localparam int DASC_TREQ_BIT = 6;
    localparam int DASC_TPLACE_BIT = 0;
    localparam int DASC_FULL_BIT = 7;
    localparam logic [7:0] DASC_CTL1_RESET = 8'h00;
    localparam logic [7:0] DASC_TCTL_RESET = 8'h00;
    localparam logic [6:0] DASC_FULL_LINES = 7'h40;
    localparam logic [1:0] DASC_BANK_A = 2'h0;
    localparam logic [1:0] DASC_BANK_B = 2'h1;
    localparam logic [1:0] DASC_BANK_C = 2'h2;
    localparam logic [1:0] DASC_BANK_NONE = 2'h3;
    typedef enum logic [2:0] {
        DASC_S0 = 3'h0,
        DASC_S1 = 3'h1,
        DASC_S2 = 3'h2,
        DASC_S3 = 3'h3,
        DASC_SF = 3'h4
    } dasc_state_e;
endpackage : dasc_pkg

// ---- verilog/dasc_core.sv ----
// Purpose: arm, trigger and state sequencer control of the debug module
// Assumes: pclk bus clock, presetn other resets, por_n power-on reset
// Notes: comparator and trace storage live outside; this core steers them
// Operation
// - arm and bank always writable; others disarmed
// - trigger bit reads zero, zero writes ignored
// - arm self-clears at trace end, untraced break
// - arming enters State1, flags become 001
// - trigger forces Final State, break after trace
// - no tracing without trace request bit
// - begin-aligned trace in progress ignores trigger
// - secured system disables tracing entirely
// - break goes to background if selected and enabled, else trap
// - final-state break at trace end or immediately
// - bank select picks comparator A, B, C, none
// - bank select picks shared register at index 27
// - full flag set at 64 stored lines
// - full flag cleared by arming and power-on
// - full flag survives other resets, shown in count
// - flags update on every sequencer transition
// - software disarm keeps last state flags
// - internal end returns to state 0, flags 000
// - flag encoding 000..100, upper codes reserved
// - status register read-only, writes ignored
// - trace request enables tracing, blocked when secured
// - placement bit chooses begin or end alignment
`timescale 1ns/1ps
`default_nettype none
module dasc_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic secured,
    input wire logic background_mode_enabled,
    input wire logic match_any,
    input wire logic match_final,
    input wire logic trace_line_stored,
    input wire logic trace_done,
    input wire logic [5:0] trace_line_count,
    input wire logic [7:0] shared_rdata,
    output logic [1:0] comparator_bank_select,
    output logic shared_wr,
    output logic [7:0] shared_wdata,
    output logic tracing,
    output logic trace_begin_aligned,
    output logic armed,
    output logic break_to_background,
    output logic break_to_trap
);
    import dasc_pkg::*;

    logic arm_reg;
    logic bgsel_reg;
    logic fbrk_reg;
    logic [1:0] bank_reg;
    logic treq_reg;
    logic tplace_reg;
    logic full_reg;
    logic [6:0] lines_reg;
    logic tracing_reg;
    logic immediate_trigger_req_pend_reg;
    logic immediate_trigger_req_late_reg;
    logic bgen_s1_reg;
    logic bgen_reg;
    logic sec_s1_reg;
    logic sec_reg;
    dasc_state_e state_reg;
    dasc_state_e state_next;
    logic [2:0] flags_reg;

    logic wr_en;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic arm_wr;
    logic immediate_trigger_req_wr;
    logic int_end;
    logic brk_fire;
    logic trace_ok;
    logic [7:0] rbyte;

    // zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign idx = {2'h0, paddr[7:2]};
    assign wbyte = pwdata[7:0];
    assign wr_en = psel && penable && pwrite;
    assign arm_wr = wr_en && idx == DASC_IDX_CTL1 && wbyte[DASC_ARM_BIT];
    assign immediate_trigger_req_wr = wr_en && idx == DASC_IDX_CTL1 && wbyte[DASC_IMMEDIATE_TRIGGER_REQ_BIT];
    assign trace_ok = treq_reg && !sec_reg;

    // the secured and background-enable pins pass two flops first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bgen_s1_reg <= 1'b0;
            bgen_reg <= 1'b0;
            sec_s1_reg <= 1'b1;
            sec_reg <= 1'b1;
        end else begin
            bgen_s1_reg <= background_mode_enabled;
            bgen_reg <= bgen_s1_reg;
            sec_s1_reg <= secured;
            sec_reg <= sec_s1_reg;
        end
    end

    // end of session: trace complete, or a break with tracing off
    // a plain expression, so the net follows every term that it reads
    assign int_end = arm_reg && ((tracing_reg && trace_done) ||
                     (!trace_ok && fbrk_reg && state_reg == DASC_SF));
    assign brk_fire = arm_reg && fbrk_reg && state_reg == DASC_SF &&
                      (trace_ok ? (tracing_reg && trace_done) : 1'b1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_reg <= DASC_CTL1_RESET[DASC_ARM_BIT];
            bgsel_reg <= DASC_CTL1_RESET[DASC_BGSEL_BIT];
            fbrk_reg <= DASC_CTL1_RESET[DASC_FBRK_BIT];
            bank_reg <= DASC_CTL1_RESET[1:0];
        end else if (wr_en && idx == DASC_IDX_CTL1) begin
            arm_reg <= wbyte[DASC_ARM_BIT] && !int_end;
            bank_reg <= wbyte[1:0];
            if (!arm_reg) begin
                bgsel_reg <= wbyte[DASC_BGSEL_BIT];
                fbrk_reg <= wbyte[DASC_FBRK_BIT];
            end
        end else if (int_end) begin
            arm_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            treq_reg <= DASC_TCTL_RESET[DASC_TREQ_BIT];
            tplace_reg <= DASC_TCTL_RESET[DASC_TPLACE_BIT];
        end else begin
            // securing wins over a write, so the request never outlives it
            if (sec_reg) begin
                treq_reg <= 1'b0;
            end else if (wr_en && idx == DASC_IDX_TCTL && !arm_reg) begin
                treq_reg <= wbyte[DASC_TREQ_BIT];
            end
            if (wr_en && idx == DASC_IDX_TCTL && !arm_reg) begin
                tplace_reg <= wbyte[DASC_TPLACE_BIT];
            end
        end
    end

    // sequencer: arming enters State1, matches advance, trigger jumps
    always_comb begin
        state_next = state_reg;
        if (arm_wr) begin
            state_next = DASC_S1;
        end else if (int_end) begin
            state_next = DASC_S0;
        end else if (arm_reg) begin
            // a trigger written with the arm bit lands one cycle after State1
            if ((immediate_trigger_req_wr || immediate_trigger_req_late_reg) && !(tracing_reg && tplace_reg)) begin
                state_next = DASC_SF;
            end else if (match_final && state_reg != DASC_SF) begin
                state_next = DASC_SF;
            end else if (match_any) begin
                unique case (state_reg)
                    DASC_S1: state_next = DASC_S2;
                    DASC_S2: state_next = DASC_S3;
                    default: state_next = state_reg;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= DASC_S0;
            flags_reg <= 3'h0;
            immediate_trigger_req_late_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            // arming owns this edge; the trigger is kept for the next one
            immediate_trigger_req_late_reg <= arm_wr && immediate_trigger_req_wr;
            if (arm_wr || int_end || (arm_reg && state_next != state_reg)) begin
                flags_reg <= state_next;
            end // software disarm leaves flags alone
        end
    end

    // tracing starts when Final State is reached under begin alignment,
    // or runs from arming under end alignment until trace end or disarm
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tracing_reg <= 1'b0;
            immediate_trigger_req_pend_reg <= 1'b0;
        end else if (!arm_reg || int_end || !trace_ok) begin
            tracing_reg <= 1'b0;
            immediate_trigger_req_pend_reg <= 1'b0;
        end else begin
            if (tplace_reg) begin
                if (state_reg == DASC_SF) begin
                    tracing_reg <= 1'b1;
                end
            end else begin
                tracing_reg <= 1'b1;
            end
            immediate_trigger_req_pend_reg <= state_reg == DASC_SF;
        end
    end

    // full flag lives on power-on reset only so other resets keep it
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            full_reg <= 1'b0;
            lines_reg <= 7'h00;
        end else if (arm_wr) begin
            full_reg <= 1'b0;
            lines_reg <= 7'h00;
        end else if (tracing_reg && trace_line_stored) begin
            if (lines_reg != DASC_FULL_LINES) begin
                lines_reg <= lines_reg + 7'h01;
            end
            if (lines_reg + 7'h01 >= DASC_FULL_LINES) begin
                full_reg <= 1'b1;
            end
        end
    end

    always_comb begin
        rbyte = 8'h00;
        if (idx == DASC_IDX_CTL1) begin
            rbyte = {arm_reg, 1'b0, 1'b0, bgsel_reg, fbrk_reg, 1'b0, bank_reg};
        end else if (idx == DASC_IDX_STAT) begin
            rbyte = {full_reg, 4'h0, flags_reg};
        end else if (idx == DASC_IDX_TCTL) begin
            rbyte = {1'b0, treq_reg, 5'h00, tplace_reg};
        end else if (idx == DASC_IDX_CNT) begin
            rbyte = {full_reg, 1'b0, trace_line_count};
        end else if (idx == DASC_IDX_SHARED) begin
            rbyte = shared_rdata;
        end else if (idx == DASC_IDX_BREAK) begin
            rbyte = {6'h00, immediate_trigger_req_pend_reg, brk_fire};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, rbyte};
        end
    end

    // unmapped indices answer with an error; writes to status are dropped
    assign pslverr = psel && penable && !(idx == DASC_IDX_CTL1 || idx == DASC_IDX_STAT ||
                     idx == DASC_IDX_TCTL || idx == DASC_IDX_CNT ||
                     idx == DASC_IDX_SHARED || idx == DASC_IDX_BREAK);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_wr <= 1'b0;
            shared_wdata <= 8'h00;
        end else begin
            shared_wr <= wr_en && idx == DASC_IDX_SHARED;
            shared_wdata <= wbyte;
        end
    end

    assign comparator_bank_select = bank_reg;
    assign tracing = tracing_reg;
    assign trace_begin_aligned = tplace_reg;
    assign armed = arm_reg;
    assign break_to_background = brk_fire && bgsel_reg && bgen_reg;
    assign break_to_trap = brk_fire && !(bgsel_reg && bgen_reg);

    chk_arm_sets_s1: assert property (@(posedge pclk) disable iff (!presetn)
        arm_wr |=> state_reg == DASC_S1 && flags_reg == 3'h1)
        else $error("arming did not enter state one");
    chk_status_ro: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == DASC_IDX_STAT && !int_end && !arm_wr) |=>
        $stable(flags_reg))
        else $error("status write changed flags");
    chk_locked_bits: assert property (@(posedge pclk) disable iff (!presetn)
        arm_reg |=> $stable(bgsel_reg) && $stable(fbrk_reg))
        else $error("break bits changed while armed");
    chk_int_end_zero: assert property (@(posedge pclk) disable iff (!presetn)
        int_end && !arm_wr |=> !arm_reg && flags_reg == 3'h0)
        else $error("internal end did not reset sequencer");
    chk_flag_legal: assert property (@(posedge pclk) disable iff (!presetn)
        flags_reg <= 3'h4)
        else $error("reserved flag code");
    chk_no_trace_off: assert property (@(posedge pclk) disable iff (!presetn)
        !trace_ok |=> !tracing_reg)
        else $error("tracing without request");
    chk_full_clear: assert property (@(posedge pclk) disable iff (!presetn)
        arm_wr |=> !full_reg)
        else $error("full flag survived arming");
    chk_break_route: assert property (@(posedge pclk) disable iff (!presetn)
        brk_fire |-> (break_to_background != break_to_trap))
        else $error("break routed twice or not at all");
    chk_swdisarm_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == DASC_IDX_CTL1 && !wbyte[DASC_ARM_BIT] && arm_reg && !int_end)
        |=> flags_reg == $past(flags_reg))
        else $error("software disarm changed flags");

    // named steps shared by the properties below
    sequence s_arm_with_immediate_trigger_req;
        arm_wr && immediate_trigger_req_wr && !int_end ##1
        arm_reg && !arm_wr && !int_end && !(tracing_reg && tplace_reg);
    endsequence

    sequence s_untraced_final;
        arm_reg && fbrk_reg && state_reg == DASC_SF && !trace_ok;
    endsequence

    sequence s_last_line;
        tracing_reg && trace_line_stored && !arm_wr &&
        lines_reg == DASC_FULL_LINES - 7'h01;
    endsequence

    // trigger and session end
    chk_arm_immediate_trigger_req_final: assert property (@(posedge pclk) disable iff (!presetn)
        s_arm_with_immediate_trigger_req |=> state_reg == DASC_SF && flags_reg == 3'h4)
        else $error("trigger written with the arm bit was lost");
    chk_untraced_break: assert property (@(posedge pclk) disable iff (!presetn)
        s_untraced_final |-> brk_fire ##1 !arm_reg)
        else $error("untraced final state gave no break");
    chk_trace_end_disarm: assert property (@(posedge pclk) disable iff (!presetn)
        (arm_reg && tracing_reg && trace_done) |=> !arm_reg && !tracing_reg)
        else $error("trace completion left the session armed");
    chk_begin_waits: assert property (@(posedge pclk) disable iff (!presetn)
        (arm_reg && tplace_reg && state_reg != DASC_SF && !tracing_reg)
        |=> !tracing_reg)
        else $error("begin aligned trace started before final state");

    // full flag sits on the power-on reset, so presetn only masks the check
    chk_full_set: assert property (@(posedge pclk) disable iff (!presetn)
        s_last_line |=> full_reg)
        else $error("full flag missed the last line");
    chk_full_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!arm_wr && !(tracing_reg && trace_line_stored))
        |=> $stable(full_reg))
        else $error("full flag moved without cause");

    // register side
    chk_secure_treq: assert property (@(posedge pclk) disable iff (!presetn)
        sec_reg |=> !treq_reg)
        else $error("trace request held while secured");
    chk_immediate_trigger_req_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && idx == DASC_IDX_CTL1)
        |=> !prdata[DASC_IMMEDIATE_TRIGGER_REQ_BIT])
        else $error("trigger bit read back as one");
    chk_bank_window: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == DASC_IDX_CTL1)
        |=> comparator_bank_select == $past(wbyte[1:0]))
        else $error("bank select did not follow the write");
    chk_shared_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == DASC_IDX_SHARED)
        |=> shared_wr && shared_wdata == $past(wbyte))
        else $error("shared register write not passed on");

    // sequencer
    chk_flags_track: assert property (@(posedge pclk) disable iff (!presetn)
        arm_reg |-> flags_reg == state_reg)
        else $error("flags differ from armed sequencer state");
    chk_s1_advance: assert property (@(posedge pclk) disable iff (!presetn)
        (arm_reg && state_reg == DASC_S1 && match_any && !match_final && !immediate_trigger_req_wr &&
        !immediate_trigger_req_late_reg && !arm_wr && !int_end) |=> state_reg == DASC_S2)
        else $error("match did not advance from state one");
    chk_disarmed_still: assert property (@(posedge pclk) disable iff (!presetn)
        (!arm_reg && !arm_wr) |=> $stable(state_reg))
        else $error("sequencer moved while disarmed");
endmodule : dasc_core
`default_nettype wire

// ---- sim/dasc_far.sv ----
// Purpose: stand-in for the comparator and trace store logic
// Assumes: bench calls its tasks; outputs change just after pclk rises
// Notes: shared registers are kept per bank and hold no reset value
`timescale 1ns/1ps
`default_nettype none
module dasc_far (
    input wire logic pclk,
    input wire logic tracing,
    input wire logic [1:0] comparator_bank_select,
    input wire logic shared_wr,
    input wire logic [7:0] shared_wdata,
    output logic match_any,
    output logic match_final,
    output logic trace_line_stored,
    output logic trace_done,
    output logic [5:0] trace_line_count,
    output logic [7:0] shared_rdata
);
    logic [7:0] bank_regs [4];
    initial {match_any, match_final, trace_line_stored, trace_done, trace_line_count} = '0;
    assign shared_rdata = bank_regs[comparator_bank_select];
    always @(posedge pclk) if (shared_wr) bank_regs[comparator_bank_select] <= shared_wdata;
    task automatic pulse_match(input logic fin);
        @(posedge pclk);
        match_any <= !fin;
        match_final <= fin;
        @(posedge pclk);
        match_any <= 1'b0;
        match_final <= 1'b0;
    endtask : pulse_match
    // a line is only stored while the core says it is tracing
    task automatic store_lines(input int n);
        repeat (n) begin
            @(posedge pclk);
            trace_line_stored <= tracing;
            trace_line_count <= trace_line_count + 6'(tracing);
            @(posedge pclk);
            trace_line_stored <= 1'b0;
        end
    endtask : store_lines
    task automatic end_trace;
        @(posedge pclk);
        trace_done <= 1'b1;
        @(posedge pclk);
        trace_done <= 1'b0;
    endtask : end_trace
endmodule : dasc_far
`default_nettype wire

// ---- sim/testbench.sv ----
// Purpose: self-checking bench for the debug arm and state control core
// Assumes: zero-wait APB slave, byte registers at index times four
// Notes: outputs are checked after a read, except tracing right after store_lines
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end
module testbench;
    import dasc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, por_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, secured = 1'b0, background_mode_enabled = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rdv;
    logic pready, pslverr, errv, match_any, match_final, trace_line_stored, trace_done;
    logic [5:0] trace_line_count;
    logic [7:0] shared_rdata, shared_wdata;
    logic [1:0] comparator_bank_select;
    logic shared_wr, tracing, trace_begin_aligned, armed, break_to_background, break_to_trap;
    logic seen_bg = 1'b0, seen_trap = 1'b0;
    int num_errors = 0, samples_checked = 0, cycles = 0;
    dasc_core uut (.pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .secured, .background_mode_enabled, .match_any,
        .match_final, .trace_line_stored, .trace_done, .trace_line_count, .shared_rdata,
        .comparator_bank_select, .shared_wr, .shared_wdata, .tracing, .trace_begin_aligned,
        .armed, .break_to_background, .break_to_trap);
    dasc_far fe (.pclk, .tracing, .comparator_bank_select, .shared_wr, .shared_wdata,
        .match_any, .match_final, .trace_line_stored, .trace_done, .trace_line_count,
        .shared_rdata);
    initial forever #4 pclk = ~pclk;
    // break outputs may last one cycle only, so remember any sighting
    always @(posedge pclk) begin
        if (break_to_background) seen_bg <= 1'b1;
        if (break_to_trap) seen_trap <= 1'b1;
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            $display("[ERR] %0t timeout", $time);
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        `CHK(rdv[7:0], e)
    endtask : rdchk
    task automatic t_regs;
        rdchk(DASC_IDX_CTL1, DASC_CTL1_RESET);
        rdchk(DASC_IDX_TCTL, DASC_TCTL_RESET);
        wr(DASC_IDX_STAT, 8'hFF);
        rdchk(DASC_IDX_STAT, 8'h00);
        apb(1'b0, 8'h10, 8'h00);
        `CHK(errv, 1'b1)
    endtask : t_regs
    task automatic t_arm;
        wr(DASC_IDX_CTL1, 8'h10);
        rdchk(DASC_IDX_CTL1, 8'h10);
        wr(DASC_IDX_CTL1, 8'h90);
        rdchk(DASC_IDX_STAT, 8'h01);
        `CHK(armed, 1'b1)
        wr(DASC_IDX_CTL1, 8'h88);
        rdchk(DASC_IDX_CTL1, 8'h90);
        fe.pulse_match(1'b0);
        rdchk(DASC_IDX_STAT, 8'h02);
        fe.pulse_match(1'b0);
        rdchk(DASC_IDX_STAT, 8'h03);
        fe.pulse_match(1'b1);
        rdchk(DASC_IDX_STAT, 8'h04);
        wr(DASC_IDX_CTL1, 8'h00);
        rdchk(DASC_IDX_CTL1, 8'h10);
        fe.pulse_match(1'b0);
        rdchk(DASC_IDX_STAT, 8'h04);
        wr(DASC_IDX_CTL1, 8'h00);
        rdchk(DASC_IDX_CTL1, 8'h00);
    endtask : t_arm
    task automatic t_bank;
        for (int b = 0; b < 4; b++) begin
            wr(DASC_IDX_CTL1, 8'(b));
            wr(DASC_IDX_SHARED, 8'hA0 + 8'(b));
            rdchk(DASC_IDX_SHARED, 8'hA0 + 8'(b));
            `CHK(comparator_bank_select, 2'(b))
        end
        wr(DASC_IDX_CTL1, 8'h00);
        rdchk(DASC_IDX_SHARED, 8'hA0);
    endtask : t_bank
    task automatic t_break;
        for (int k = 1; k < 4; k++) begin
            background_mode_enabled <= k[0];
            wr(DASC_IDX_CTL1, {3'h0, k[1], 4'h8});
            seen_bg <= 1'b0;
            seen_trap <= 1'b0;
            wr(DASC_IDX_CTL1, {3'h6, k[1], 4'h8});
            repeat (2) @(posedge pclk);
            rdchk(DASC_IDX_CTL1, {3'h0, k[1], 4'h8});
            rdchk(DASC_IDX_STAT, 8'h00);
            `CHK(tracing, 1'b0)
            `CHK(seen_bg, k == 3)
            `CHK(seen_trap, k != 3)
        end
        wr(DASC_IDX_CTL1, 8'h00);
    endtask : t_break
    task automatic t_trace;
        wr(DASC_IDX_TCTL, 8'h40);
        rdchk(DASC_IDX_TCTL, 8'h40);
        wr(DASC_IDX_CTL1, 8'hC0);
        @(posedge pclk);
        fe.store_lines(64);
        `CHK(tracing, 1'b1)
        rdchk(DASC_IDX_STAT, 8'h84);
        rdchk(DASC_IDX_CNT, 8'h80);
        fe.end_trace();
        rdchk(DASC_IDX_CTL1, 8'h00);
        rdchk(DASC_IDX_STAT, 8'h80);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(DASC_IDX_STAT, 8'h80);
        wr(DASC_IDX_TCTL, 8'h41);
        wr(DASC_IDX_CTL1, 8'h80);
        rdchk(DASC_IDX_STAT, 8'h01);
        `CHK(trace_begin_aligned, 1'b1)
        wr(DASC_IDX_CTL1, 8'h00);
        wr(DASC_IDX_TCTL, 8'h00);
    endtask : t_trace
    task automatic t_secure;
        secured <= 1'b1;
        wr(DASC_IDX_TCTL, 8'h40);
        rdchk(DASC_IDX_TCTL, 8'h00);
        wr(DASC_IDX_CTL1, 8'hC0);
        rdchk(DASC_IDX_STAT, 8'h04);
        `CHK(tracing, 1'b0)
        wr(DASC_IDX_CTL1, 8'h00);
        secured <= 1'b0;
    endtask : t_secure
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        t_regs();
        t_arm();
        t_bank();
        t_break();
        t_trace();
        t_secure();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
